/* File: inc/bjb_cfg.svh */
/*
 bit positions and bus parameters for the bus to chain bridge.
 assumes a 4-bit processor data bus and a single system clock.
*/
`ifndef BJB_CFG_SVH
`define BJB_CFG_SVH
`define BJB_DATA_W 4
`define BJB_ADDR_W 8
`define BJB_CHAIN_ADDR 8'h40
`define BJB_BIT_TDI 0
`define BJB_BIT_TMS 1
`define BJB_BIT_TCK 2
`define BJB_BIT_TDO 3
`define BJB_RST_LINES 3'h0
`endif

/* File: inc/bjb_pkg.sv */
/*
 types for the bus to chain bridge.
 assumes bjb_cfg.svh is on the include path.
*/
`include "bjb_cfg.svh"
package bjb_pkg;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bjb_lines_t;
endpackage

/* File: rtl/bjb_bridge.sv */
/*
 processor bus to test chain bridge with cable override.
 assumes bus strobes and cable pins are asynchronous and need synchronising.
*/
`timescale 1ns/1ps
`include "bjb_cfg.svh"
////////////////////////////////////////////////////////////////////////
// What this block does
// - chain is reached by reads and writes to one bus address, or to any address when the bypass strap is set
// - address, read select and strobe decode into chain access and direction
// - writes capture data bits into three registers on the system clock
// - test mode, clock and data outputs come straight from registers
// - registers run on the system clock; bus strobe, read select and cable pins reach it through synchronisers
// - data bus driven only during a chain read, carrying chain data out
// - reads also return the three register values for checking
// - cable select lets a download cable drive the chain lines
// - data bits mandatory; address decode optional via a bypass strap, strobe and read select still used
module bjb_bridge
    import bjb_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [`BJB_ADDR_W-1:0] i_bus_addr,
    input wire logic i_read_not_write_select,
    input wire logic i_bus_address_strobe,
    input wire logic i_decode_bypass,
    input wire logic [`BJB_DATA_W-1:0] i_bus_data,
    input wire logic i_chain_tdo,
    input wire logic i_cable_select,
    input wire logic i_cable_tck,
    input wire logic i_cable_tms,
    input wire logic i_cable_tdi,
    output logic [`BJB_DATA_W-1:0] o_bus_data,
    output logic o_bus_data_oe,
    output logic o_chain_tck,
    output logic o_chain_tms,
    output logic o_chain_tdi,
    output logic o_cable_tdo
);
    ////////////////////////////////////////////////////////////////////
    // three-stage synchronisers for pins
    localparam int NS = 8;
    logic [NS-1:0] pin_in;
    wire [NS-1:0] clean_w;
    assign pin_in = {i_bus_address_strobe, i_read_not_write_select, i_chain_tdo, i_cable_select,
                     i_cable_tck, i_cable_tms, i_cable_tdi, i_decode_bypass};
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_sync
            // per-bit registers, so no vector is written by two processes
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic clean_r;
            always_ff @(posedge i_clock) begin
                if (i_reset) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    clean_r <= 1'b0;
                end else begin
                    s1_r <= pin_in[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // a change counts once two stages agree
                    if (s2_r == s3_r) begin
                        clean_r <= s3_r;
                    end
                end
            end
            assign clean_w[g] = clean_r;
        end
    endgenerate
    wire strobe_s = clean_w[7];
    wire rnw_s = clean_w[6];
    wire tdo_s = clean_w[5];
    wire cab_sel_s = clean_w[4];
    wire cab_tck_s = clean_w[3];
    wire cab_tms_s = clean_w[2];
    wire cab_tdi_s = clean_w[1];
    wire bypass_s = clean_w[0];
    ////////////////////////////////////////////////////////////////////
    // address decode
    // data and address are registered every clock and used when the synchronised strobe rises, so
    // the bus must hold them stable while the strobe is asserted
    logic strobe_d_r;
    logic [`BJB_ADDR_W-1:0] addr_r;
    logic [`BJB_DATA_W-1:0] data_r;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            strobe_d_r <= 1'b0;
            addr_r <= '0;
            data_r <= '0;
        end else begin
            strobe_d_r <= strobe_s;
            addr_r <= i_bus_addr;
            data_r <= i_bus_data;
        end
    end
    wire addr_hit = bypass_s || (addr_r == `BJB_CHAIN_ADDR);
    wire access_start = strobe_s && !strobe_d_r && addr_hit;
    wire wr_go = access_start && !rnw_s;
    wire rd_active = strobe_s && rnw_s && addr_hit;
    ////////////////////////////////////////////////////////////////////
    // chain line registers, one capture per access
    bjb_lines_t lines_r;
    bjb_lines_t lines_nxt;
    assign lines_nxt = wr_go ? bjb_lines_t'{tck: data_r[`BJB_BIT_TCK], tms: data_r[`BJB_BIT_TMS],
                                           tdi: data_r[`BJB_BIT_TDI]} : lines_r;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            lines_r <= `BJB_RST_LINES;
        end else begin
            lines_r <= lines_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // cable override and read-back
    bjb_lines_t out_nxt;
    logic [`BJB_DATA_W-1:0] rd_nxt;
    assign out_nxt = cab_sel_s ? bjb_lines_t'{tck: cab_tck_s, tms: cab_tms_s, tdi: cab_tdi_s} : lines_r;
    assign rd_nxt = {tdo_s, lines_r.tck, lines_r.tms, lines_r.tdi};
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_chain_tck <= 1'b0;
            o_chain_tms <= 1'b0;
            o_chain_tdi <= 1'b0;
            o_bus_data <= '0;
            o_bus_data_oe <= 1'b0;
            o_cable_tdo <= 1'b0;
        end else begin
            o_chain_tck <= out_nxt.tck;
            o_chain_tms <= out_nxt.tms;
            o_chain_tdi <= out_nxt.tdi;
            o_bus_data <= rd_active ? rd_nxt : '0;
            o_bus_data_oe <= rd_active;
            o_cable_tdo <= tdo_s;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // checks
    a_write_capture: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go && !cab_sel_s |=> ##1 (o_chain_tck == $past(data_r[`BJB_BIT_TCK], 2)))
        else $error("chain clock did not follow write");
    a_hold_no_write: assert property (@(posedge i_clock) disable iff (i_reset)
        !wr_go |=> $stable(lines_r))
        else $error("line registers changed without write");
    a_oe_read_only: assert property (@(posedge i_clock) disable iff (i_reset)
        o_bus_data_oe |-> $past(rd_active))
        else $error("bus driven outside a chain read");
    a_tdo_on_read: assert property (@(posedge i_clock) disable iff (i_reset)
        rd_active |=> o_bus_data[`BJB_BIT_TDO] == $past(tdo_s))
        else $error("chain data out missing on read");
    a_readback: assert property (@(posedge i_clock) disable iff (i_reset)
        rd_active |=> o_bus_data[2:0] == $past(lines_r))
        else $error("read-back mismatch");
    a_cable_mux: assert property (@(posedge i_clock) disable iff (i_reset)
        cab_sel_s |=> o_chain_tms == $past(cab_tms_s))
        else $error("cable did not take the chain");
    a_reg_drive: assert property (@(posedge i_clock) disable iff (i_reset)
        !cab_sel_s |=> o_chain_tdi == $past(lines_r.tdi))
        else $error("data in not from register");
    a_one_per_strobe: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |=> !wr_go)
        else $error("two captures for one strobe");
    a_quiet_bus: assert property (@(posedge i_clock) disable iff (i_reset)
        !o_bus_data_oe |-> o_bus_data == '0)
        else $error("data bus not quiet");
    // counts captures per strobe; a glitchy strobe would show as two
    logic [1:0] wr_seen_r;
    always_ff @(posedge i_clock) begin
        if (i_reset || !strobe_s) begin
            wr_seen_r <= 2'h0;
        end else if (wr_go && wr_seen_r != 2'h3) begin
            wr_seen_r <= wr_seen_r + 2'h1;
        end
    end
    a_single_capture: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |-> wr_seen_r == 2'h0)
        else $error("second capture within one strobe");
    a_write_dir: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |-> !rnw_s)
        else $error("capture during a read access");
    a_wr_addr_hit: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |-> addr_hit)
        else $error("capture without address match");
    a_miss_no_write: assert property (@(posedge i_clock) disable iff (i_reset)
        strobe_s && !addr_hit |=> $stable(lines_r))
        else $error("foreign address changed the lines");
    a_miss_no_drive: assert property (@(posedge i_clock) disable iff (i_reset)
        strobe_s && !addr_hit |=> !o_bus_data_oe)
        else $error("foreign address drove the bus");
    a_tck_capture: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |=> lines_r.tck == $past(data_r[`BJB_BIT_TCK]))
        else $error("clock register not captured");
    a_tms_capture: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |=> lines_r.tms == $past(data_r[`BJB_BIT_TMS]))
        else $error("mode register not captured");
    a_tdi_capture: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_go |=> lines_r.tdi == $past(data_r[`BJB_BIT_TDI]))
        else $error("data in register not captured");
    a_reg_tck: assert property (@(posedge i_clock) disable iff (i_reset)
        !cab_sel_s |=> o_chain_tck == $past(lines_r.tck))
        else $error("chain clock not from register");
    a_reg_tms: assert property (@(posedge i_clock) disable iff (i_reset)
        !cab_sel_s |=> o_chain_tms == $past(lines_r.tms))
        else $error("chain mode not from register");
    a_cable_tck: assert property (@(posedge i_clock) disable iff (i_reset)
        cab_sel_s |=> o_chain_tck == $past(cab_tck_s))
        else $error("cable clock did not reach chain");
    a_cable_tdi: assert property (@(posedge i_clock) disable iff (i_reset)
        cab_sel_s |=> o_chain_tdi == $past(cab_tdi_s))
        else $error("cable data did not reach chain");
    a_cable_tdo_out: assert property (@(posedge i_clock) disable iff (i_reset)
        1'b1 |=> o_cable_tdo == $past(tdo_s))
        else $error("chain data out not returned to cable");
    a_oe_on_read: assert property (@(posedge i_clock) disable iff (i_reset)
        rd_active |=> o_bus_data_oe)
        else $error("chain read did not drive the bus");
    a_drop_after_read: assert property (@(posedge i_clock) disable iff (i_reset)
        !strobe_s |=> !o_bus_data_oe)
        else $error("bus still driven after strobe fell");
endmodule

/* File: bench/bjb_chain_model.sv */
/*
 one-stage chain device model.
 assumes tck and tdi come from the bridge.
*/
`timescale 1ns/1ps
module bjb_chain_model (
    input wire logic i_tck,
    input wire logic i_tdi,
    output logic o_tdo
);
    // tdo shows the bit taken at the last tck rise
    initial o_tdo = 1'b0;
    always @(posedge i_tck) o_tdo <= i_tdi;
endmodule

/* File: bench/testbench.sv */
/*
 self-checking bench for the bus to chain bridge.
 assumes bjb_pkg and the chain model are compiled first.
*/
`timescale 1ns/1ps
`include "bjb_cfg.svh"
module testbench;
    import bjb_pkg::*;
    logic i_clock, i_reset, rnw, stb, byp, tdo, csel, ctck, ctms, ctdi, oe, tck, tms, tdi, ctdo;
    logic [7:0] addr, a;
    logic [3:0] wd, rd, d;
    logic [4:0] q;
    logic [2:0] exp_l = 3'h0;
    logic exp_tdo = 1'b0;
    int err_count = 0, n_compared = 0, cyc = 0, seed = 32'hb8d55b51;
    bjb_bridge i_bjb_bridge (.i_clock(i_clock), .i_reset(i_reset), .i_bus_addr(addr),
        .i_read_not_write_select(rnw), .i_bus_address_strobe(stb), .i_decode_bypass(byp),
        .i_bus_data(wd), .i_chain_tdo(tdo), .i_cable_select(csel), .i_cable_tck(ctck),
        .i_cable_tms(ctms), .i_cable_tdi(ctdi), .o_bus_data(rd), .o_bus_data_oe(oe),
        .o_chain_tck(tck), .o_chain_tms(tms), .o_chain_tdi(tdi), .o_cable_tdo(ctdo));
    bjb_chain_model i_bjb_chain_model (.i_tck(tck), .i_tdi(tdi), .o_tdo(tdo));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic next_tdo(input logic [2:0] o, input logic [2:0] n, input logic t);
        return (!o[2] && n[2]) ? n[0] : t;
    endfunction
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // strobe held 8 clocks, low 6: the sync path needs both
    task automatic acc(input logic [7:0] ad, input logic r, input logic [3:0] dv, output logic [4:0] qv);
        @(negedge i_clock);
        addr = ad;
        rnw = r;
        wd = dv;
        stb = 1'b1;
        repeat (8) @(negedge i_clock);
        qv = {oe, rd};
        stb = 1'b0;
        repeat (6) @(negedge i_clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        {i_reset, rnw, stb, byp, csel, ctck, ctms, ctdi} = 8'h80;
        addr = 8'h00;
        wd = 4'h0;
        repeat (12) @(negedge i_clock);
        i_reset = 1'b0;
        cmp({oe, tck, tms, tdi}, 4'h0);
        for (int k = 0; k < 40; k++) begin
            a = (k % 4 == 3) ? 8'h41 : `BJB_CHAIN_ADDR;
            byp = (k % 8 == 7);
            d = 4'($random(seed));
            d[1:0] = d[2] ? exp_l[1:0] : d[1:0];
            acc(a, 1'b0, d, q);
            if (a == `BJB_CHAIN_ADDR || byp) begin
                exp_tdo = next_tdo(exp_l, d[2:0], exp_tdo);
                exp_l = d[2:0];
            end
            cmp({1'b0, tck, tms, tdi}, {1'b0, exp_l});
            acc(`BJB_CHAIN_ADDR, 1'b1, 4'h0, q);
            cmp(q[3:0], {exp_tdo, exp_l});
            cmp({3'h0, q[4]}, 4'h1);
            cmp({3'h0, oe}, 4'h0);
            cmp({3'h0, ctdo}, {3'h0, exp_tdo});
        end
        byp = 1'b0;
        acc(8'h41, 1'b1, 4'h0, q);
        cmp(q[3:0], 4'h0);
        cmp({3'h0, q[4]}, 4'h0);
        csel = 1'b1;
        for (int k = 0; k < 8; k++) begin
            d = {1'b0, k[0], k[2:1]};
            {ctck, ctms, ctdi} = d[2:0];
            repeat (10) @(negedge i_clock);
            exp_tdo = next_tdo(exp_l, d[2:0], exp_tdo);
            exp_l = d[2:0];
            cmp({ctdo, tck, tms, tdi}, {exp_tdo, exp_l});
        end
        stop_test();
    end
endmodule
